// file: hv_seq_pkg.sv
`default_nettype none
package hv_seq_pkg;
    // time base: one prescaler tick per millisecond
    localparam int CLK_MHZ         = 250;
    localparam int TICK_US         = 1000;
    localparam int PRESCALE_CYCLES = CLK_MHZ * TICK_US;

    // delays in their own units, then in prescaler ticks
    localparam int WARMUP_MIN      = 3;
    localparam int WARMUP_TICKS    = WARMUP_MIN * 60 * 1000000 / TICK_US;
    localparam int STEP_DELAY_MS   = 150;
    localparam int STEP_TICKS      = (STEP_DELAY_MS * 1000 + TICK_US - 1) / TICK_US;
    localparam int RECYCLE_S       = 5;
    localparam int RECYCLE_TICKS   = RECYCLE_S * 1000000 / TICK_US;
    localparam int DEBOUNCE_MS     = 10;
    localparam int DEBOUNCE_TICKS  = (DEBOUNCE_MS * 1000 + TICK_US - 1) / TICK_US;

    // positions of the synchronised inputs
    localparam int IN_HEAT_START   = 0;
    localparam int IN_HEAT_STOP    = 1;
    localparam int IN_HV_START     = 2;
    localparam int IN_HV_STOP      = 3;
    localparam int IN_DOOR_OK      = 4;
    localparam int IN_CHIMNEY_OK   = 5;
    localparam int IN_BREAKER      = 6;
    localparam int IN_AIRFLOW_TRIP = 7;
    localparam int IN_GRID_TRIP    = 8;
    localparam int IN_PLATE_TRIP   = 9;
    localparam int IN_REMOTE_SEL   = 10;
    localparam int IN_REM_STOP_OK  = 11;
    localparam int IN_REM_START    = 12;
    localparam int N_IN            = 13;

    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_RECYCLE_BIT    = 0;
    localparam logic CTRL_RECYCLE_RST  = 1'b0;

    // status fields
    localparam int ST_FILAMENT   = 0;
    localparam int ST_PLATE_HOLD = 1;
    localparam int ST_WARM_DONE  = 2;
    localparam int ST_PLATE_ON   = 3;
    localparam int ST_BYPASS     = 4;
    localparam int ST_READY      = 5;
    localparam int ST_REC_START  = 6;
    localparam int ST_REMOTE     = 7;
    localparam int ST_RECYCLE_EN = 8;
endpackage
`default_nettype wire

// file: hv_power_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - heater start latches filament contactor, which runs heaters, blower and warm-up timer
// - heater stop, door and chimney interlocks feed both starts; opening drops all latches
// - hv start sets plate hold latch only with no trips, breaker closed, airflow fine
// - setting plate hold also latches filament contactor, lamp and warm-up timer
// - warm-up done rises three minutes after the timer input becomes active
// - warm heaters give immediate plate power; otherwise wait out the warm-up
// - plate contactor and hv lamp on exactly when plate hold and warm-up done
// - plate contactor first feeds transformers through the step-start resistor
// - step-start bypass closes 0.15 s after plate contactor
// - plate hold clearing drops contactor and bypass and re-arms the bypass delay
// - hv stop clears only the plate path; heaters and blower stay on
// - heater stop removes heater, bias, screen and plate power always
// - remote mode feeds control through a normally closed remote stop contact
// - remote start sets plate hold with the same gating, as sequence start
// - airflow or heat trip clears plate hold
// - grid overload clears plate hold
// - plate overload clears plate hold
// - enabled recycle unit supplies the remote feed and asserts remote start
// - plate-ready follows warm-up; five seconds later the recycle start releases
// - power status follows plate contactor; with recycle enabled, indicator when on, alarm when off
// - plate hold clearing drops plate-ready; recycle start returns at once
// - retry gives plate-ready after warm-up if heaters dropped, else immediately
module hv_power_sequencer
    import hv_seq_pkg::*;
#(
    parameter int PRESCALE   = PRESCALE_CYCLES,
    parameter int WARMUP_TK  = WARMUP_TICKS,
    parameter int RECYCLE_TK = RECYCLE_TICKS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // operator panel, high while pressed
    input  wire logic        heater_start_button,
    input  wire logic        heater_stop_button,
    input  wire logic        hv_start_button,
    input  wire logic        hv_stop_button,
    // interlocks and trips
    input  wire logic        door_interlock_closed,
    input  wire logic        chimney_interlock_closed,
    input  wire logic        main_breaker,
    input  wire logic        airflow_heat_trip,
    input  wire logic        grid_overload_trip,
    input  wire logic        plate_overload_trip,
    // remote station
    input  wire logic        control_source_select,
    input  wire logic        remote_stop_closed,
    input  wire logic        remote_start,
    // contactors and lamps
    output logic             filament_contactor,
    output logic             heater_lamp,
    output logic             plate_contactor,
    output logic             hv_lamp,
    output logic             step_start_bypass,
    // recycle and status terminals
    output logic             plate_ready,
    output logic             power_on_status,
    output logic             remote_indicator,
    output logic             alarm_drive,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    localparam int PRE_W  = $clog2(PRESCALE + 1);
    localparam int WARM_W = $clog2(WARMUP_TK + 1);
    localparam int STEP_W = $clog2(STEP_TICKS + 1);
    localparam int REC_W  = $clog2(RECYCLE_TK + 1);
    localparam int DEB_W  = $clog2(DEBOUNCE_TICKS + 1);

    typedef struct packed {
        logic [N_IN-1:0]            meta;
        logic [N_IN-1:0]            sync;
        logic [N_IN-1:0]            db;
        logic [N_IN-1:0][DEB_W-1:0] dcnt;
        logic [PRE_W-1:0]           pre;
        logic                       tick;
        logic                       filament;
        logic                       plate_hold;
        logic [WARM_W-1:0]          warm_cnt;
        logic                       warm_done;
        logic                       plate_on;
        logic [STEP_W-1:0]          step_cnt;
        logic                       bypass;
        logic                       ready;
        logic [REC_W-1:0]           rec_cnt;
        logic                       rec_start;
        logic                       recycle_en;
        logic                       power_on;
        logic                       rem_ind;
        logic                       alarm;
        logic                       waitreq;
        logic [31:0]                rdata;
    } state_t;

    state_t q;
    state_t d;

    logic        remote_mode;
    logic        ctrl_feed;
    logic        all_feed;
    logic        hv_feed;
    logic        gate_ok;
    logic        start_req;
    logic        hold_next;
    logic [31:0] status_w;

    always_comb begin
        d = q;
        d.meta[IN_HEAT_START]   = heater_start_button;
        d.meta[IN_HEAT_STOP]    = heater_stop_button;
        d.meta[IN_HV_START]     = hv_start_button;
        d.meta[IN_HV_STOP]      = hv_stop_button;
        d.meta[IN_DOOR_OK]      = door_interlock_closed;
        d.meta[IN_CHIMNEY_OK]   = chimney_interlock_closed;
        d.meta[IN_BREAKER]      = main_breaker;
        d.meta[IN_AIRFLOW_TRIP] = airflow_heat_trip;
        d.meta[IN_GRID_TRIP]    = grid_overload_trip;
        d.meta[IN_PLATE_TRIP]   = plate_overload_trip;
        d.meta[IN_REMOTE_SEL]   = control_source_select;
        d.meta[IN_REM_STOP_OK]  = remote_stop_closed;
        d.meta[IN_REM_START]    = remote_start;
        d.sync = q.meta;

        // millisecond prescaler
        d.tick = 1'b0;
        if (q.pre == PRE_W'(PRESCALE - 1)) begin
            d.pre  = '0;
            d.tick = 1'b1;
        end else begin
            d.pre = q.pre + 1'b1;
        end

        // a change is accepted once it has stood for the debounce time
        for (int i = 0; i < N_IN; i++) begin
            if (q.sync[i] == q.db[i]) begin
                d.dcnt[i] = '0;
            end else if (q.tick) begin
                if (q.dcnt[i] == DEB_W'(DEBOUNCE_TICKS - 1)) begin
                    d.db[i]   = q.sync[i];
                    d.dcnt[i] = '0;
                end else begin
                    d.dcnt[i] = q.dcnt[i] + 1'b1;
                end
            end
        end

        // control feed chain; heater stop and interlocks sit in series ahead of every start, hv stop and trips only ahead of hv starts
        remote_mode = q.db[IN_REMOTE_SEL];
        ctrl_feed = !remote_mode || q.db[IN_REM_STOP_OK] || q.recycle_en;
        all_feed  = ctrl_feed && q.db[IN_DOOR_OK] && q.db[IN_CHIMNEY_OK]
                    && !q.db[IN_HEAT_STOP];
        hv_feed   = all_feed && !q.db[IN_HV_STOP];
        gate_ok   = !q.db[IN_GRID_TRIP] && !q.db[IN_PLATE_TRIP]
                    && q.db[IN_BREAKER] && !q.db[IN_AIRFLOW_TRIP];
        start_req = q.db[IN_HV_START]
                    || (remote_mode && (q.db[IN_REM_START] || q.rec_start));
        hold_next = hv_feed && gate_ok && (q.plate_hold || start_req);
        d.plate_hold = hold_next;

        // sequence start behaves as a heater start press
        d.filament = all_feed
                     && (q.filament || q.db[IN_HEAT_START] || hold_next);

        // warm-up timer runs from whichever path latched the heaters
        if (!d.filament) begin
            d.warm_cnt  = '0;
            d.warm_done = 1'b0;
        end else if (q.tick && !q.warm_done) begin
            d.warm_cnt  = q.warm_cnt + 1'b1;
            d.warm_done = (q.warm_cnt == WARM_W'(WARMUP_TK - 1));
        end

        // plate path: resistor in circuit until the bypass closes
        d.plate_on = hold_next && q.warm_done;
        if (!hold_next) begin
            d.step_cnt = '0;
            d.bypass   = 1'b0;
        end else if (q.plate_on && !q.bypass && q.tick) begin
            d.step_cnt = q.step_cnt + 1'b1;
            d.bypass   = (q.step_cnt == STEP_W'(STEP_TICKS - 1));
        end

        // recycle hold timer
        d.ready = hold_next && q.warm_done;
        if (!q.ready) begin
            d.rec_cnt = '0;
        end else if (q.tick && q.rec_cnt != REC_W'(RECYCLE_TK)) begin
            d.rec_cnt = q.rec_cnt + 1'b1;
        end
        d.rec_start = q.recycle_en
                      && !(q.ready && q.rec_cnt == REC_W'(RECYCLE_TK));

        // status terminals
        d.power_on = q.plate_on;
        d.rem_ind  = q.recycle_en && q.plate_on;
        d.alarm    = q.recycle_en && !q.plate_on;

        status_w = '0;
        status_w[ST_FILAMENT]   = q.filament;
        status_w[ST_PLATE_HOLD] = q.plate_hold;
        status_w[ST_WARM_DONE]  = q.warm_done;
        status_w[ST_PLATE_ON]   = q.plate_on;
        status_w[ST_BYPASS]     = q.bypass;
        status_w[ST_READY]      = q.ready;
        status_w[ST_REC_START]  = q.rec_start;
        status_w[ST_REMOTE]     = remote_mode;
        status_w[ST_RECYCLE_EN] = q.recycle_en;

        // bus: one wait cycle, then a single low waitrequest cycle
        d.waitreq = 1'b1;
        if ((avs_read || avs_write) && q.waitreq) begin
            d.waitreq = 1'b0;
            d.rdata   = '0;
            if (avs_read && avs_address == ADDR_CTRL) begin
                d.rdata[CTRL_RECYCLE_BIT] = q.recycle_en;
            end else if (avs_read && avs_address == ADDR_STATUS) begin
                d.rdata = status_w;
            end
        end
        if (avs_write && !q.waitreq && avs_address == ADDR_CTRL && avs_byteenable[0]) begin
            d.recycle_en = avs_writedata[CTRL_RECYCLE_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q            <= '0;
            q.waitreq    <= 1'b1;
            q.recycle_en <= CTRL_RECYCLE_RST;
        end else begin
            q <= d;
        end
    end

    assign filament_contactor = q.filament;
    assign heater_lamp        = q.filament;
    assign plate_contactor    = q.plate_on;
    assign hv_lamp            = q.plate_on;
    assign step_start_bypass  = q.bypass;
    assign plate_ready        = q.ready;
    assign power_on_status    = q.power_on;
    assign remote_indicator   = q.rem_ind;
    assign alarm_drive        = q.alarm;
    assign avs_readdata       = q.rdata;
    assign avs_waitrequest    = q.waitreq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_PLATE_EXACT: assert property (
        q.plate_on == (q.plate_hold && $past(q.warm_done)))
        else $error("plate contactor not equal to hold and warm-up");
    AST_WARMUP_COUNT: assert property (
        $rose(q.warm_done) |-> q.filament && q.warm_cnt == WARM_W'(WARMUP_TK))
        else $error("warm-up done at wrong count");
    AST_BYPASS_LATE: assert property (
        $rose(q.bypass) |-> q.plate_on && $past(q.plate_on)
                           && q.step_cnt == STEP_W'(STEP_TICKS))
        else $error("bypass closed without full step delay");
    AST_HOLD_DROP: assert property (
        $fell(q.plate_hold) |-> !q.plate_on && !q.bypass && q.step_cnt == '0)
        else $error("plate path left on after hold cleared");
    AST_SEQ_START: assert property (
        $rose(q.plate_hold) |-> q.filament)
        else $error("sequence start without filament");
    AST_HV_STOP: assert property (
        (q.db[IN_HV_STOP] && all_feed && q.filament) |=> q.filament && !q.plate_hold)
        else $error("hv stop disturbed heaters or kept plate");
    AST_HEAT_STOP: assert property (
        q.db[IN_HEAT_STOP] |=> !q.filament && !q.plate_hold && !q.plate_on)
        else $error("heater stop left power on");
    AST_TRIP: assert property (
        (q.db[IN_GRID_TRIP] || q.db[IN_PLATE_TRIP] || q.db[IN_AIRFLOW_TRIP])
        |=> !q.plate_hold && !q.plate_on)
        else $error("trip did not clear plate hold");
    AST_RETRY: assert property (
        (q.recycle_en && $fell(q.ready)) |=> q.rec_start)
        else $error("recycle start not reasserted");
    AST_STATUS: assert property (
        q.power_on == $past(q.plate_on) && (q.alarm != q.rem_ind || !$past(q.recycle_en)))
        else $error("power status not following contactor");

    // heater latch and control feed
    AST_FIL_LATCH: assert property (
        (q.db[IN_HEAT_START] && all_feed) |=> q.filament)
        else $error("heater start did not latch filament");
    AST_FIL_KEEP: assert property (
        (q.filament && all_feed) |=> q.filament)
        else $error("filament latch dropped with feed present");
    AST_FEED_DROP: assert property (
        !all_feed |=> !q.filament && !q.plate_hold)
        else $error("latch kept after feed opened");
    AST_REMOTE_FEED: assert property (
        (remote_mode && !q.db[IN_REM_STOP_OK] && !q.recycle_en) |=> !q.filament)
        else $error("remote stop contact did not cut feed");

    // plate hold gating
    AST_HOLD_GATE: assert property (
        $rose(q.plate_hold) |-> $past(hv_feed && gate_ok))
        else $error("plate hold set without gating");
    AST_HOLD_KEEP: assert property (
        (q.plate_hold && hv_feed && gate_ok) |=> q.plate_hold)
        else $error("plate hold released while gated on");
    AST_REMOTE_START: assert property (
        (remote_mode && q.db[IN_REM_START] && hv_feed && gate_ok) |=> q.plate_hold)
        else $error("remote start did not set plate hold");
    AST_AIRFLOW: assert property (
        q.db[IN_AIRFLOW_TRIP] |=> !q.plate_hold)
        else $error("airflow trip did not clear plate hold");
    AST_PLATE_TRIP: assert property (
        q.db[IN_PLATE_TRIP] |=> !q.plate_hold)
        else $error("plate overload did not clear plate hold");
    AST_STOP_WINS: assert property (
        (q.db[IN_HV_STOP] && q.db[IN_HV_START]) |=> !q.plate_hold)
        else $error("start beat stop in the same cycle");

    // warm-up and plate path
    AST_WARM_CLEAR: assert property (
        !q.filament |-> !q.warm_done && q.warm_cnt == '0)
        else $error("warm-up timer running without filament");
    AST_COLD_WAIT: assert property (
        (q.plate_hold && !q.warm_done) |=> !q.plate_on)
        else $error("plate on before warm-up done");
    AST_SOFT_START: assert property (
        $rose(q.plate_on) |-> !q.bypass)
        else $error("plate contactor closed with bypass shorted");

    // recycle and status
    AST_RECYCLE_START: assert property (
        (q.recycle_en && !q.ready) |=> q.rec_start)
        else $error("recycle start missing while not ready");
    AST_REC_HOLD: assert property (
        (q.recycle_en && q.ready && q.rec_cnt != REC_W'(RECYCLE_TK)) |=> q.rec_start)
        else $error("recycle start released early");
    AST_REC_RELEASE: assert property (
        (q.ready && q.rec_cnt == REC_W'(RECYCLE_TK)) |=> !q.rec_start)
        else $error("recycle start not released");
    AST_IND_ALARM: assert property (
        q.rem_ind == ($past(q.recycle_en) && $past(q.plate_on))
        && q.alarm == ($past(q.recycle_en) && !$past(q.plate_on)))
        else $error("indicator or alarm wrong");
    AST_READY_DROP: assert property (
        $fell(q.plate_hold) |-> !q.ready)
        else $error("plate ready kept after hold cleared");
    AST_RETRY_WARM: assert property (
        ($rose(q.plate_hold) && q.warm_done) |=> q.ready || !q.plate_hold)
        else $error("warm retry did not give ready at once");

    // time base and debounce
    AST_PRESCALE: assert property (
        q.tick |-> q.pre == '0)
        else $error("prescaler tick out of phase");
    AST_DEBOUNCE: assert property (
        (q.db != $past(q.db)) |-> $past(q.tick))
        else $error("debounced input changed off a tick");

    COV_PLATE_ON: cover property ($rose(q.plate_on));
    COV_BYPASS: cover property ($rose(q.bypass));
    COV_TRIP: cover property ($fell(q.plate_hold) && q.filament);
    COV_RETRY: cover property ($rose(q.rec_start) ##[1:20] q.plate_hold);
    COV_SEQ_START: cover property ($rose(q.plate_hold) && !$past(q.filament));
endmodule
`default_nettype wire

// file: panel_model.sv
`timescale 1ns/10ps
`default_nettype none
module panel_model
    import hv_seq_pkg::*;
(
    // clock
    input  wire logic       clk,
    // pin levels seen by the sequencer
    output logic [N_IN-1:0] pins
);
    // interlocks and breaker closed, remote stop held closed
    initial pins = 13'h0870;

    // flip one pin for cyc clocks, then put it back: buttons and trips
    // pulse high, interlocks and contacts open for the period
    // heaters may be stopped without the cool-down wait
    // the alarm enable switch is outside and never closed here
    task automatic press(input int idx, input int cyc);
        fork
            begin
                pins[idx] <= ~pins[idx];
                repeat (cyc) @(posedge clk);
                pins[idx] <= ~pins[idx];
            end
        join_none
    endtask
endmodule
`default_nettype wire

// file: tb_hv_power_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_hv_power_sequencer
    import hv_seq_pkg::*;
;
    localparam int PS = 4;
    localparam int WU = 20;
    localparam int RC = 5;
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    logic [N_IN-1:0] p;
    logic [3:0]      adr = 4'h0;
    logic            rd = 1'b0;
    logic            wr = 1'b0;
    logic [31:0]     wd = 32'h0;
    logic [31:0]     rdat;
    logic [31:0]     q;
    logic            fil, hl, pc, hvl, byp, rdy, pos, rind, alm, wrq;
    logic [8:0]      ov;
    int              n_errors = 0;
    int              num_checks = 0;
    int              t0;
    int              tr[3] = '{IN_AIRFLOW_TRIP, IN_GRID_TRIP, IN_PLATE_TRIP};

    always #2 clk = ~clk;
    assign ov = {alm, rind, pos, rdy, byp, hvl, pc, hl, fil};

    panel_model pm (.clk(clk), .pins(p));

    hv_power_sequencer #(.PRESCALE(PS), .WARMUP_TK(WU), .RECYCLE_TK(RC)) uut (
        .clk(clk), .reset(reset),
        .heater_start_button(p[IN_HEAT_START]), .heater_stop_button(p[IN_HEAT_STOP]),
        .hv_start_button(p[IN_HV_START]), .hv_stop_button(p[IN_HV_STOP]),
        .door_interlock_closed(p[IN_DOOR_OK]), .chimney_interlock_closed(p[IN_CHIMNEY_OK]),
        .main_breaker(p[IN_BREAKER]), .airflow_heat_trip(p[IN_AIRFLOW_TRIP]),
        .grid_overload_trip(p[IN_GRID_TRIP]), .plate_overload_trip(p[IN_PLATE_TRIP]),
        .control_source_select(p[IN_REMOTE_SEL]), .remote_stop_closed(p[IN_REM_STOP_OK]),
        .remote_start(p[IN_REM_START]),
        .filament_contactor(fil), .heater_lamp(hl), .plate_contactor(pc),
        .hv_lamp(hvl), .step_start_bypass(byp), .plate_ready(rdy),
        .power_on_status(pos), .remote_indicator(rind), .alarm_drive(alm),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_byteenable(4'hf),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wrq)
    );

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wrq !== 1'b0 && i < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i >= 50) begin
            n_errors++;
            $display("Error at %0t: bus timeout", $time);
            complete_run();
        end
    endtask

    // wait for output k to reach v; t0 holds the cycles taken
    task automatic wt(input int k, input logic v, input int lim);
        t0 = 0;
        while (ov[k] !== v && t0 < lim) begin
            @(posedge clk);
            t0++;
        end
        num_checks++;
        if (t0 >= lim) begin
            n_errors++;
            $display("Error at %0t: output %0d stuck", $time, k);
            complete_run();
        end
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        chk(ov, 9'h0);
        chk(wrq, 1'b1);
        bus(1'b0, ADDR_CTRL, 32'h0);
        chk(q, {31'h0, CTRL_RECYCLE_RST});
        pm.press(IN_HEAT_START, 60);
        wt(0, 1'b1, 80);
        chk({hl, pc}, 2'h2);
        repeat (WU * PS + 80) @(posedge clk);
        pm.press(IN_HV_START, 60);
        wt(2, 1'b1, 80);
        chk(byp, 1'b0);
        wt(4, 1'b1, STEP_TICKS * PS + 8);
        chk(32'(t0 >= (STEP_TICKS - 1) * PS), 32'h1);
        chk({hvl, rdy}, 2'h3);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q, 32'h3f);
        pm.press(IN_HV_STOP, 60);
        pm.press(IN_HV_START, 60);
        wt(2, 1'b0, 80);
        repeat (100) @(posedge clk);
        chk({fil, pc, byp}, 3'h4);
        for (int k = 0; k < 3; k++) begin
            pm.press(IN_HV_START, 60);
            wt(2, 1'b1, 80);
            chk(byp, 1'b0);
            pm.press(tr[k], 200);
            wt(2, 1'b0, 80);
            chk({fil, byp}, 2'h2);
            pm.press(IN_HV_START, 60);
            repeat (250) @(posedge clk);
            chk(pc, 1'b0);
        end
        pm.press(IN_HEAT_STOP, 60);
        wt(0, 1'b0, 80);
        repeat (100) @(posedge clk);
        pm.press(IN_HV_START, 60);
        wt(0, 1'b1, 80);
        chk({hl, pc}, 2'h2);
        wt(2, 1'b1, WU * PS + 20);
        chk(32'(t0 >= (WU - 1) * PS), 32'h1);
        pm.press(IN_DOOR_OK, 60);
        wt(0, 1'b0, 80);
        chk(pc, 1'b0);
        repeat (120) @(posedge clk);
        pm.press(IN_REMOTE_SEL, 20000);
        repeat (80) @(posedge clk);
        bus(1'b1, ADDR_CTRL, 32'h1);
        wt(0, 1'b1, 100);
        wt(5, 1'b1, WU * PS + 80);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q[ST_REC_START], 1'b1);
        chk({pos, rind, alm}, 3'h6);
        repeat (RC * PS + 10) @(posedge clk);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q[ST_REC_START], 1'b0);
        pm.press(IN_GRID_TRIP, 60);
        wt(2, 1'b0, 80);
        repeat (2) @(posedge clk);
        chk({rdy, alm}, 2'h1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(q[ST_REC_START], 1'b1);
        wt(2, 1'b1, 120);
        bus(1'b0, 4'h8, 32'h0);
        chk(q, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
